// *** shared/icts_defs.vh ***
// constants for impedance calibration and thermal status block
`ifndef ICTS_DEFS_VH
`define ICTS_DEFS_VH

// clock and time figures
`define ICTS_CLK_PS          25000
`define ICTS_CAL_RUN_NS      1000
`define ICTS_LOAD_NS         30
`define ICTS_LOAD_NCK        8
`define ICTS_CLEAR_NS        50
`define ICTS_CLEAR_NCK       3
`define ICTS_TSI_MS          32
`define ICTS_OFS_MAX_US      200

// derived cycle counts: least times round up, longest round down
`define ICTS_CAL_RUN_CYC     (((`ICTS_CAL_RUN_NS * 1000) + `ICTS_CLK_PS - 1) / `ICTS_CLK_PS)
`define ICTS_LOAD_CYC        (((`ICTS_LOAD_NS * 1000) + `ICTS_CLK_PS - 1) / `ICTS_CLK_PS)
`define ICTS_CLEAR_CYC       (((`ICTS_CLEAR_NS * 1000) + `ICTS_CLK_PS - 1) / `ICTS_CLK_PS)
`define ICTS_TSI_CYC         ((`ICTS_TSI_MS * 1000000) / (`ICTS_CLK_PS / 1000))

// per channel register word offsets (word index paddr[4:2] within a channel window)
`define ICTS_OFS_IO_CONFIG   3'h0
`define ICTS_OFS_TERM        3'h1
`define ICTS_OFS_CAL_RESET   3'h2
`define ICTS_OFS_TEMP_STAT   3'h3
`define ICTS_OFS_MPC         3'h4
`define ICTS_OFS_CAL_STAT    3'h5
`define ICTS_CH_BIT          5

// field positions
`define ICTS_PU_POINT_BIT    0
`define ICTS_PD_STR_HI       5
`define ICTS_PD_STR_LO       3
`define ICTS_DQ_TERM_HI      2
`define ICTS_DQ_TERM_LO      0
`define ICTS_CA_TERM_HI      6
`define ICTS_CA_TERM_LO      4
`define ICTS_TOFS_HI         6
`define ICTS_TOFS_LO         5
`define ICTS_TSTAT_HI        2
`define ICTS_TSTAT_LO        0
`define ICTS_MPC_BOTH_BIT    8

// multipurpose command codes
`define ICTS_MPC_CAL_BEGIN   8'h4f
`define ICTS_MPC_CAL_LOAD    8'h51

// reset values
`define ICTS_IO_CONFIG_RST   8'h31
`define ICTS_TERM_RST        8'h00
`define ICTS_CAL_CODE_RST    6'h20

`endif

// *** design/icts_interval.v ***
// minimum interval timer counting both core cycles and link clock edges
`timescale 1ns/1ps
module icts_interval #(
   parameter CW = 8,
   parameter EW = 4
) (
   input  wire          i_mclk,
   input  wire          i_rst,
   input  wire          i_start,
   input  wire          i_ck_rise,
   input  wire [CW-1:0] i_min_cyc,
   input  wire [EW-1:0] i_min_edges,
   output wire          o_busy,
   output reg           o_done
);
   reg  [CW-1:0] cyc_q;
   reg  [EW-1:0] edg_q;
   reg           busy_q;
   wire [CW-1:0] cyc_d = (cyc_q != {CW{1'b0}}) ? cyc_q - {{(CW-1){1'b0}}, 1'b1} : cyc_q;
   wire [EW-1:0] edg_d = (i_ck_rise && edg_q != {EW{1'b0}}) ?
                         edg_q - {{(EW-1){1'b0}}, 1'b1} : edg_q;

   assign o_busy = busy_q;

   always @(posedge i_mclk) begin
      if (i_rst) begin
         cyc_q  <= {CW{1'b0}};
         edg_q  <= {EW{1'b0}};
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else if (i_start) begin
         cyc_q  <= i_min_cyc;
         edg_q  <= i_min_edges;
         busy_q <= 1'b1;
         o_done <= 1'b0;
      end else begin
         cyc_q  <= cyc_d;
         edg_q  <= edg_d;
         busy_q <= busy_q && (cyc_d != {CW{1'b0}} || edg_d != {EW{1'b0}});
         o_done <= busy_q && cyc_d == {CW{1'b0}} && edg_d == {EW{1'b0}};
      end
   end
endmodule

// *** design/icts_top.v ***
// two channel impedance calibration control and temperature status, apb slave
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "icts_defs.vh"

// Notes on behaviour
// - two-bit thermal offset per channel, affects only that channel's status
// - offset write refreshes that channel's status within a few cycles
// - sensor sampled and status refreshed every sensor update interval
// - leaving power-down or self refresh forces a fresh status update
// - sensor code arrives pre-thresholded with 2 degree margin; passed through
// - multipurpose command decodes calibration begin and calibration load
// - driver code changes only after load or clear and its interval elapse
// - clear bit resets code to default; guard busy max(50 ns, 3 clocks)
// - clear touches only the channel that wrote it
// - shared engine starts only when idle; extra begins ignored
// - begin accepted on either or both channels, other commands still run
// - each channel loads only on its own load; both-channel form allowed
// - load takes the latest completed result
module icts_top #(
   parameter P_TSI_CYC = `ICTS_TSI_CYC,
   parameter CODE_W    = 6
) (
   input  wire                i_mclk,
   input  wire                i_rst,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [7:0]          paddr,
   input  wire [31:0]         pwdata,
   output wire                pready,
   output reg  [31:0]         prdata,
   output wire                pslverr,
   input  wire                i_ck,
   input  wire [2:0]          i_sensor_code,
   input  wire [CODE_W-1:0]   i_cal_meas,
   input  wire [1:0]          i_low_power,
   output wire [1:0]          o_pullup_cal_point,
   output wire [5:0]          o_pulldown_drive_strength,
   output wire [5:0]          o_data_lane_termination,
   output wire [5:0]          o_cmd_bus_termination,
   output wire [2*CODE_W-1:0] o_drv_code,
   output wire [5:0]          o_temperature_status,
   output wire [3:0]          o_temp_compensated_refresh,
   output wire                o_cal_busy,
   output wire [1:0]          o_cmd_guard
);
   localparam TW = 21;
   // integer figures, cut to counter widths below
   localparam integer  TSI_LAST_I  = P_TSI_CYC - 1;
   localparam integer  RUN_CYC_I   = `ICTS_CAL_RUN_CYC;
   localparam integer  LOAD_CYC_I  = `ICTS_LOAD_CYC;
   localparam integer  CLEAR_CYC_I = `ICTS_CLEAR_CYC;
   localparam integer  LOAD_NCK_I  = `ICTS_LOAD_NCK;
   localparam integer  CLEAR_NCK_I = `ICTS_CLEAR_NCK;
   localparam [TW-1:0] TSI_LAST    = TSI_LAST_I[TW-1:0];
   localparam [7:0]    RUN_CYC     = RUN_CYC_I[7:0];
   localparam [7:0]    LOAD_CYC    = LOAD_CYC_I[7:0];
   localparam [7:0]    CLEAR_CYC   = CLEAR_CYC_I[7:0];
   localparam [3:0]    LOAD_NCK    = LOAD_NCK_I[3:0];
   localparam [3:0]    CLEAR_NCK   = CLEAR_NCK_I[3:0];
   localparam [1:0]    G_IDLE      = 2'b00;
   localparam [1:0]    G_LOAD      = 2'b01;
   localparam [1:0]    G_CLEAR     = 2'b10;

   // saturating sum of sensor code and thermal offset
   function [2:0] temp_adj;
      input [2:0] code;
      input [1:0] ofs;
      reg   [3:0] sum;
      begin
         sum = {1'b0, code} + {2'b00, ofs};
         temp_adj = sum[3] ? 3'h7 : sum[2:0];
      end
   endfunction

   // refresh rate class from a status code
   function [1:0] refresh_class;
      input [2:0] stat;
      begin
         case (stat)
            3'h0, 3'h1, 3'h2: refresh_class = 2'b00;
            3'h3:             refresh_class = 2'b01;
            3'h4, 3'h5:       refresh_class = 2'b10;
            default:          refresh_class = 2'b11;
         endcase
      end
   endfunction

   // pin synchronisers
   reg  [2:0]        ck_s1_q, ck_s2_q;
   reg  [2:0]        sens_s1_q, sens_s2_q;
   reg  [CODE_W-1:0] meas_s1_q, meas_s2_q;
   reg  [1:0]        lp_s1_q, lp_s2_q, lp_d_q;
   reg               ck_last_q;
   reg  [2:0]        ck_fill_q;
   // no edge until the synchroniser holds real pin history
   wire              ck_rise = ck_s2_q[0] & ~ck_last_q & ck_fill_q[2];

   always @(posedge i_mclk) begin
      if (i_rst) begin
         ck_s1_q   <= 3'h0;
         ck_s2_q   <= 3'h0;
         ck_last_q <= 1'b0;
         ck_fill_q <= 3'h0;
         sens_s1_q <= 3'h0;
         sens_s2_q <= 3'h0;
         meas_s1_q <= {CODE_W{1'b0}};
         meas_s2_q <= {CODE_W{1'b0}};
         lp_s1_q   <= 2'b00;
         lp_s2_q   <= 2'b00;
         lp_d_q    <= 2'b00;
      end else begin
         ck_s1_q   <= {2'b00, i_ck};
         ck_s2_q   <= ck_s1_q;
         ck_last_q <= ck_s2_q[0];
         ck_fill_q <= {ck_fill_q[1:0], 1'b1};
         sens_s1_q <= i_sensor_code;
         sens_s2_q <= sens_s1_q;
         meas_s1_q <= i_cal_meas;
         meas_s2_q <= meas_s1_q;
         lp_s1_q   <= i_low_power;
         lp_s2_q   <= lp_s1_q;
         lp_d_q    <= lp_s2_q;
      end
   end

   // apb decode
   wire       acc     = psel & penable;
   wire       ch      = paddr[`ICTS_CH_BIT];
   wire [2:0] widx    = paddr[4:2];
   wire       mapped  = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                        (widx <= `ICTS_OFS_CAL_STAT);
   wire       wr      = acc & pwrite & mapped;
   wire       wr_mpc  = wr && widx == `ICTS_OFS_MPC;
   wire       both    = pwdata[`ICTS_MPC_BOTH_BIT];
   wire [1:0] ch_sel  = both ? 2'b11 : (ch ? 2'b10 : 2'b01);

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // command decode per channel
   wire [1:0] begin_req = (wr_mpc && pwdata[7:0] == `ICTS_MPC_CAL_BEGIN) ? ch_sel : 2'b00;
   wire [1:0] load_req  = (wr_mpc && pwdata[7:0] == `ICTS_MPC_CAL_LOAD) ? ch_sel : 2'b00;
   wire [1:0] clear_req;
   assign clear_req[0] = wr && !ch && widx == `ICTS_OFS_CAL_RESET && pwdata[0];
   assign clear_req[1] = wr && ch && widx == `ICTS_OFS_CAL_RESET && pwdata[0];

   // shared calibration engine
   wire              run_busy;
   wire              run_done;
   wire              run_start = (|begin_req) & ~run_busy;
   reg  [CODE_W-1:0] done_code_q;
   reg               done_valid_q;

   icts_interval #(.CW(8), .EW(4)) u_run (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_start     (run_start),
      .i_ck_rise   (ck_rise),
      .i_min_cyc   (RUN_CYC),
      .i_min_edges (4'h0),
      .o_busy      (run_busy),
      .o_done      (run_done)
   );

   // latest completed result, shared record
   always @(posedge i_mclk) begin
      if (i_rst) begin
         done_code_q  <= `ICTS_CAL_CODE_RST;
         done_valid_q <= 1'b0;
      end else if (run_done) begin
         done_code_q  <= meas_s2_q;
         done_valid_q <= 1'b1;
      end
   end

   assign o_cal_busy = run_busy;

   // per channel state
   reg  [7:0]        io_cfg_q   [0:1];
   reg  [7:0]        term_q     [0:1];
   reg  [1:0]        tofs_q     [0:1];
   reg  [2:0]        tstat_q    [0:1];
   reg  [CODE_W-1:0] pend_q     [0:1];
   reg  [CODE_W-1:0] act_q      [0:1];
   reg  [1:0]        gst_q      [0:1];
   reg  [1:0]        tupd_q;
   reg  [TW-1:0]     tsi_q;
   wire              tsi_tick = (tsi_q == TSI_LAST);
   wire [1:0]        g_busy;
   wire [1:0]        g_done;

   // sensor update interval timer
   always @(posedge i_mclk) begin
      if (i_rst) begin
         tsi_q <= {TW{1'b0}};
      end else if (tsi_tick) begin
         tsi_q <= {TW{1'b0}};
      end else begin
         tsi_q <= tsi_q + {{(TW-1){1'b0}}, 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gch
         wire       g_start = load_req[g] | clear_req[g];
         wire [7:0] g_cyc   = clear_req[g] ? CLEAR_CYC : LOAD_CYC;
         wire [3:0] g_nck   = clear_req[g] ? CLEAR_NCK : LOAD_NCK;
         wire       wr_ch   = wr && (ch == g);

         icts_interval #(.CW(8), .EW(4)) u_guard (
            .i_mclk      (i_mclk),
            .i_rst       (i_rst),
            .i_start     (g_start),
            .i_ck_rise   (ck_rise),
            .i_min_cyc   (g_cyc),
            .i_min_edges (g_nck),
            .o_busy      (g_busy[g]),
            .o_done      (g_done[g])
         );

         // mode fields
         always @(posedge i_mclk) begin
            if (i_rst) begin
               io_cfg_q[g] <= `ICTS_IO_CONFIG_RST;
               term_q[g]   <= `ICTS_TERM_RST;
               tofs_q[g]   <= 2'b00;
            end else begin
               if (wr_ch && widx == `ICTS_OFS_IO_CONFIG) begin
                  io_cfg_q[g] <= pwdata[7:0];
               end
               if (wr_ch && widx == `ICTS_OFS_TERM) begin
                  term_q[g] <= pwdata[7:0];
               end
               if (wr_ch && widx == `ICTS_OFS_TEMP_STAT) begin
                  tofs_q[g] <= pwdata[`ICTS_TOFS_HI:`ICTS_TOFS_LO];
               end
            end
         end

         // temperature status update
         always @(posedge i_mclk) begin
            if (i_rst) begin
               tupd_q[g]  <= 1'b1;
               tstat_q[g] <= 3'h0;
            end else begin
               tupd_q[g] <= (wr_ch && widx == `ICTS_OFS_TEMP_STAT) ||
                            (lp_d_q[g] && !lp_s2_q[g]);
               if (tupd_q[g] || tsi_tick) begin
                  tstat_q[g] <= temp_adj(sens_s2_q, tofs_q[g]);
               end
            end
         end

         // load and clear sequencing of driver code
         always @(posedge i_mclk) begin
            if (i_rst) begin
               gst_q[g]  <= G_IDLE;
               pend_q[g] <= `ICTS_CAL_CODE_RST;
               act_q[g]  <= `ICTS_CAL_CODE_RST;
            end else if (clear_req[g]) begin
               gst_q[g]  <= G_CLEAR;
               pend_q[g] <= `ICTS_CAL_CODE_RST;
            end else if (load_req[g]) begin
               gst_q[g]  <= G_LOAD;
               pend_q[g] <= (run_done ? meas_s2_q : done_code_q);
            end else begin
               case (gst_q[g])
                  G_IDLE: begin
                     gst_q[g] <= G_IDLE;
                  end
                  G_LOAD, G_CLEAR: begin
                     if (g_done[g]) begin
                        act_q[g] <= pend_q[g];
                        gst_q[g] <= G_IDLE;
                     end
                  end
                  default: begin
                     gst_q[g] <= G_IDLE;
                  end
               endcase
            end
         end

         assign o_pullup_cal_point[g] = io_cfg_q[g][`ICTS_PU_POINT_BIT];
         assign o_pulldown_drive_strength[3*g+2:3*g] =
            io_cfg_q[g][`ICTS_PD_STR_HI:`ICTS_PD_STR_LO];
         assign o_data_lane_termination[3*g+2:3*g] =
            term_q[g][`ICTS_DQ_TERM_HI:`ICTS_DQ_TERM_LO];
         assign o_cmd_bus_termination[3*g+2:3*g] =
            term_q[g][`ICTS_CA_TERM_HI:`ICTS_CA_TERM_LO];
         assign o_drv_code[CODE_W*g+CODE_W-1:CODE_W*g] = act_q[g];
         assign o_temperature_status[3*g+2:3*g] = tstat_q[g];
         assign o_temp_compensated_refresh[2*g+1:2*g] = refresh_class(tstat_q[g]);
         assign o_cmd_guard[g] = g_busy[g];
      end
   endgenerate

   // read mux, captured in the setup cycle so data stands through access
   reg  [31:0] rd_mux;
   wire        rd_setup = psel & ~penable & ~pwrite & mapped;

   always @* begin
      rd_mux = 32'h0000_0000;
      case (widx)
         `ICTS_OFS_IO_CONFIG: begin
            rd_mux[7:0] = io_cfg_q[ch];
         end
         `ICTS_OFS_TERM: begin
            rd_mux[7:0] = term_q[ch];
         end
         `ICTS_OFS_TEMP_STAT: begin
            rd_mux[`ICTS_TOFS_HI:`ICTS_TOFS_LO]   = tofs_q[ch];
            rd_mux[`ICTS_TSTAT_HI:`ICTS_TSTAT_LO] = tstat_q[ch];
         end
         `ICTS_OFS_CAL_STAT: begin
            rd_mux[0]            = run_busy;
            rd_mux[1]            = g_busy[ch];
            rd_mux[2]            = gst_q[ch] == G_LOAD;
            rd_mux[3]            = done_valid_q;
            rd_mux[CODE_W+7:8]   = act_q[ch];
            rd_mux[CODE_W+15:16] = done_code_q;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge i_mclk) begin
      if (i_rst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= rd_setup ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

// *** verification/icts_ctl_model.sv ***
// controller side: command clock and reference measurement
`timescale 1ns/1ps
module icts_ctl_model (
   input  wire [5:0] i_meas,
   output reg        o_ck,
   output wire [5:0] o_cal_meas
);
   initial begin
      o_ck = 1'b0;
      #37;
      forever #100 o_ck = ~o_ck;
   end
   assign o_cal_meas = i_meas;
endmodule

// *** verification/icts_monitor.sv ***
// concurrent checks on the icts_top ports
`timescale 1ns/1ps
module icts_monitor #(
   parameter P_TSI_CYC = 200,
   parameter CODE_W    = 6
) (
   input wire                i_mclk,
   input wire                i_rst,
   input wire                psel,
   input wire                penable,
   input wire                pwrite,
   input wire [7:0]          paddr,
   input wire [31:0]         pwdata,
   input wire                i_ck,
   input wire [2:0]          i_sensor_code,
   input wire [2*CODE_W-1:0] o_drv_code,
   input wire [5:0]          o_temperature_status,
   input wire [3:0]          o_temp_compensated_refresh,
   input wire                o_cal_busy,
   input wire [1:0]          o_cmd_guard
);
   reg  [5:0] bcnt_q;
   reg  [7:0] ecnt_q;
   reg  [1:0] g_q;
   reg  [2:0] t0_q;
   reg  [2:0] ck_q;
   wire       acc  = psel & penable;
   wire       cmdw = acc & pwrite & (paddr[7:6] == 2'h0) & (paddr[4:0] == 5'h10);
   wire [3:0] tsum = {1'b0, i_sensor_code} + {2'h0, pwdata[6:5]};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   function [1:0] tcr_of(input [2:0] s);
      tcr_of = (s < 3'h3) ? 2'h0 : (s == 3'h3) ? 2'h1 : (s < 3'h6) ? 2'h2 : 2'h3;
   endfunction
   always @(posedge i_mclk) begin
      ck_q   <= {ck_q[1:0], i_ck};
      g_q    <= o_cmd_guard;
      bcnt_q <= o_cal_busy ? bcnt_q + 6'h01 : 6'h00;
      ecnt_q <= o_cmd_guard[0] ? ecnt_q + {7'h00, ck_q[1] & ~ck_q[2]} : 8'h00;
      if (acc & pwrite & (paddr == 8'h0c))
         t0_q <= (tsum > 4'h7) ? 3'h7 : tsum[2:0];
   end
   chk_begin_start: assert property (
      cmdw && pwdata[7:0] == 8'h4f && !o_cal_busy |=> o_cal_busy)
      else $error("begin did not start");
   chk_busy_len: assert property ($fell(o_cal_busy) |-> bcnt_q == 6'h28)
      else $error("busy length wrong");
   chk_load_guard: assert property (
      cmdw && pwdata[8:0] == 9'h051 && !paddr[5] |=> o_cmd_guard[0] [*2])
      else $error("load gave no guard");
   chk_guard_edges: assert property ($fell(o_cmd_guard[0]) |-> ecnt_q >= 8'h03)
      else $error("guard ended early");
   chk_hold_ch0: assert property ($changed(o_drv_code[5:0]) |->
      !o_cmd_guard[0] && (g_q[0] || $past(g_q[0])))
      else $error("ch0 code moved early");
   chk_hold_ch1: assert property ($changed(o_drv_code[11:6]) |->
      !o_cmd_guard[1] && (g_q[1] || $past(g_q[1])))
      else $error("ch1 code moved early");
   chk_temp_upd: assert property (
      acc && pwrite && paddr == 8'h0c && i_sensor_code == $past(i_sensor_code, 4)
      |-> ##[1:4] o_temperature_status[2:0] == t0_q)
      else $error("status not updated");
   chk_tcr_map: assert property (
      o_temp_compensated_refresh == {tcr_of(o_temperature_status[5:3]),
      tcr_of(o_temperature_status[2:0])})
      else $error("refresh class wrong");
endmodule

// *** verification/tb.sv ***
// self-checking bench for icts_top
`timescale 1ns/1ps
`include "icts_defs.vh"
module tb;
   reg         i_mclk, i_rst, psel, penable, pwrite, er;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata, rd;
   reg  [2:0]  i_sensor_code;
   reg  [1:0]  i_low_power;
   reg  [5:0]  meas;
   reg  [24:0] rows [0:7];
   wire        pready, pslverr, i_ck, o_cal_busy;
   wire [31:0] prdata;
   wire [5:0]  i_cal_meas, pd, dt, ct, ts;
   wire [1:0]  pu, o_cmd_guard;
   wire [11:0] o_drv_code;
   wire [3:0]  tcr;
   integer     miscompares, total_checks, cyc, i, n;
   icts_top #(.P_TSI_CYC(200)) dut_u (
      .i_mclk, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .i_ck, .i_sensor_code, .i_cal_meas, .i_low_power,
      .o_pullup_cal_point(pu), .o_pulldown_drive_strength(pd),
      .o_data_lane_termination(dt), .o_cmd_bus_termination(ct), .o_drv_code,
      .o_temperature_status(ts), .o_temp_compensated_refresh(tcr), .o_cal_busy,
      .o_cmd_guard
   );
   icts_ctl_model far_u (.i_meas(meas), .o_ck(i_ck), .o_cal_meas(i_cal_meas));
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge i_mclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge i_mclk);
         penable <= 1'b1;
         @(posedge i_mclk);
         while (pready !== 1'b1) begin
            @(posedge i_mclk);
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wait_lo(input integer w);
      begin
         n = 0;
         @(posedge i_mclk);
         while ((w == 2 ? o_cal_busy : o_cmd_guard[w]) !== 1'b0) begin
            @(posedge i_mclk);
            n = n + 1;
         end
         repeat (2) @(posedge i_mclk);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge i_mclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         tally_and_finish;
      end
   end
   initial begin
      miscompares = 0;
      total_checks = 0;
      cyc = 0;
      i_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      i_sensor_code = 3'h3;
      i_low_power = 2'h0;
      meas = 6'h2a;
      rows[0] = {8'h00, 8'h35, 8'h35, 1'b0};
      rows[1] = {8'h20, 8'h28, 8'h28, 1'b0};
      rows[2] = {8'h04, 8'h53, 8'h53, 1'b0};
      rows[3] = {8'h24, 8'h17, 8'h17, 1'b0};
      rows[4] = {8'h28, 8'h01, 8'h00, 1'b0};
      rows[5] = {8'h40, 8'h11, 8'h00, 1'b1};
      rows[6] = {8'h01, 8'h11, 8'h00, 1'b1};
      rows[7] = {8'h18, 8'h11, 8'h00, 1'b1};
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, `ICTS_IO_CONFIG_RST);
      chk(o_drv_code, {2{`ICTS_CAL_CODE_RST}});
      for (i = 0; i < 8; i = i + 1) begin
         apb(1'b1, rows[i][24:17], {24'h0, rows[i][16:9]});
         wait_lo(1);
         apb(1'b0, rows[i][24:17], 32'h0);
         chk(rd, {24'h0, rows[i][8:1]});
         chk(er, rows[i][0]);
      end
      chk({pu, pd}, {2'h1, 3'h5, 3'h6});
      chk({ct, dt}, {3'h1, 3'h5, 3'h7, 3'h3});
      wait_lo(1);
      apb(1'b1, 8'h20, 32'h29);
      apb(1'b1, 8'h10, 32'h14f);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[0], 1'b1);
      wait_lo(2);
      apb(1'b1, 8'h10, 32'h51);
      wait_lo(0);
      chk(n >= 50, 1'b1);
      chk(o_drv_code, {6'h20, 6'h2a});
      meas <= 6'h15;
      apb(1'b1, 8'h30, 32'h4f);
      apb(1'b1, 8'h10, 32'h4f);
      apb(1'b1, 8'h30, 32'h51);
      wait_lo(1);
      chk(o_drv_code, {6'h2a, 6'h2a});
      wait_lo(2);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[21:16], 6'h15);
      apb(1'b1, 8'h10, 32'h151);
      wait_lo(0);
      wait_lo(1);
      chk(o_drv_code, {6'h15, 6'h15});
      apb(1'b1, 8'h28, 32'h1);
      wait_lo(1);
      chk(n >= 12, 1'b1);
      chk(o_drv_code, {6'h20, 6'h15});
      apb(1'b1, 8'h0c, 32'h40);
      repeat (4) @(posedge i_mclk);
      chk({tcr, ts}, {2'h1, 2'h2, 3'h3, 3'h5});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h45);
      i_sensor_code <= 3'h6;
      repeat (210) @(posedge i_mclk);
      chk({tcr, ts}, {4'hf, 3'h6, 3'h7});
      i_low_power <= 2'h1;
      repeat (4) @(posedge i_mclk);
      i_sensor_code <= 3'h1;
      repeat (4) @(posedge i_mclk);
      i_low_power <= 2'h0;
      repeat (8) @(posedge i_mclk);
      chk(ts[2:0], 3'h3);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      chk({o_cal_busy, o_cmd_guard, o_drv_code}, {3'h0, 6'h20, 6'h20});
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, `ICTS_IO_CONFIG_RST);
      tally_and_finish;
   end
endmodule
bind icts_top icts_monitor #(.P_TSI_CYC(P_TSI_CYC), .CODE_W(CODE_W)) mon_u (.*);
